// >>> edp_top.sv
// Purpose: Encoder divided quadrature and origin pulse output with APB
// Assumes: Encoder gives quadrature A/B and an index Z on pins
// Notes:   Settings apply at reset or after a restart command
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module edp_top
  import edp_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              enc_a_in,
  input  wire logic              enc_b_in,
  input  wire logic              enc_z_in,
  output logic                   quad_phase_a_out,
  output logic                   quad_phase_a_out_n,
  output logic                   quad_phase_b_out,
  output logic                   quad_phase_b_out_n,
  output logic                   origin_pulse_out,
  output logic                   origin_pulse_out_n
);

  // Pending settings and the copies in use
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt, ctrl_act_r, ctrl_act_nxt;
  logic [31:0]       ppr_r, ppr_nxt, ppr_act_r, ppr_act_nxt;
  logic [31:0]       lres_r, lres_nxt, lres_act_r, lres_act_nxt;
  logic [31:0]       enc_r, enc_nxt, enc_act_r, enc_act_nxt;
  logic [15:0]       rspd_r, rspd_nxt, rspd_act_r, rspd_act_nxt;
  logic [6:0]        lspd_r, lspd_nxt, lspd_act_r, lspd_act_nxt;
  logic              restart_r, restart_nxt;
  logic              cfg_ok_r, cfg_ok_nxt;
  logic              seq_err_r, seq_err_nxt;

  // APB answer
  logic [31:0]       prdata_nxt;
  logic              pready_nxt;
  logic              pslverr_nxt;

  // Encoder side
  logic              enc_a_s, enc_b_s, enc_z_s;
  logic [1:0]        enc_idx_r, enc_idx_nxt;
  logic              z_prev_r, z_prev_nxt;
  logic              last_fwd_r, last_fwd_nxt;

  // Output side
  logic [1:0]        q_r, q_nxt;
  logic              c_r, c_nxt;
  logic              c_pend_r, c_pend_nxt;
  logic [31:0]       pos_r, pos_nxt;
  logic              a_nxt, b_nxt;

  // Comb helpers
  logic              access, commit, wr_commit;
  logic              hit, bad_val;
  logic [31:0]       rd_word;
  logic [1:0]        enc_idx, enc_diff;
  logic              enc_step, motor_fwd, z_rise;
  logic              out_en;
  logic              div_step, div_dir;
  logic [33:0]       div_num;
  logic [39:0]       lin_rate;

  edp_sync2 u_sync_a (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (enc_a_in),
    .q     (enc_a_s)
  );

  edp_sync2 u_sync_b (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (enc_b_in),
    .q     (enc_b_s)
  );

  edp_sync2 u_sync_z (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (enc_z_in),
    .q     (enc_z_s)
  );

  // Encoder counts are scaled to output edges per revolution or pitch
  always_comb begin
    div_num = ctrl_act_r[CTRL_LINEAR] ? {lres_act_r, 2'b00}
                                      : {ppr_act_r, 2'b00};
  end

  edp_rate_div u_div (
    .clk      (pclk),
    .rst_n    (presetn),
    .step_in  (enc_step & out_en),
    .dir_in   (motor_fwd ^ ctrl_act_r[CTRL_REVERSE]),
    .num      (div_num),
    .den      (enc_act_r),
    .step_out (div_step),
    .dir_out  (div_dir)
  );

  // Register file and APB slave, answering one cycle into access
  always_comb begin
    access    = psel & penable;
    commit    = access & pready;
    wr_commit = commit & pwrite;
    hit       = 1'b1;
    rd_word   = '0;
    case (paddr)
      CTRL_OFS:    rd_word = {28'h000_0000, ctrl_r};
      PPR_OFS:     rd_word = ppr_r;
      LRES_OFS:    rd_word = lres_r;
      ENC_CNT_OFS: rd_word = enc_r;
      RSPD_OFS:    rd_word = {16'h0000, rspd_r};
      LSPD_OFS:    rd_word = {25'h000_0000, lspd_r};
      STATUS_OFS: begin
        rd_word[ST_CFG_OK]                = cfg_ok_r;
        rd_word[ST_SEQ_ERR]               = seq_err_r;
        rd_word[ST_C_PENDING]             = c_pend_r;
        rd_word[ST_C_OUT]                 = c_r;
        rd_word[ST_PHASE_LO +: 2]         = q_r;
      end
      POS_OFS:     rd_word = pos_r;
      default:     hit = 1'b0;
    endcase
    bad_val = 1'b0;
    if (pwrite) begin
      case (paddr)
        PPR_OFS:     bad_val = (pwdata < PPR_MIN) || (pwdata > PPR_MAX);
        LRES_OFS:    bad_val = (pwdata == 32'h0000_0000);
        ENC_CNT_OFS: bad_val = (pwdata == 32'h0000_0000);
        RSPD_OFS:    bad_val = (pwdata[31:16] != 16'h0000);
        LSPD_OFS:    bad_val = (pwdata < {25'h000_0000, LSPD_MIN}) ||
                               (pwdata > {25'h000_0000, LSPD_MAX});
        default:     bad_val = 1'b0;
      endcase
    end
    pready_nxt  = access & ~pready;
    prdata_nxt  = (pready_nxt & ~pwrite) ? rd_word : 32'h0000_0000;
    pslverr_nxt = pready_nxt & (~hit | bad_val);

    ctrl_nxt    = ctrl_r;
    ppr_nxt     = ppr_r;
    lres_nxt    = lres_r;
    enc_nxt     = enc_r;
    rspd_nxt    = rspd_r;
    lspd_nxt    = lspd_r;
    restart_nxt = 1'b0;
    if (wr_commit & ~pslverr) begin
      case (paddr)
        CTRL_OFS: begin
          ctrl_nxt    = pwdata[CTRL_W-1:0];
          restart_nxt = pwdata[CTRL_RESTART];
        end
        PPR_OFS:     ppr_nxt  = pwdata;
        LRES_OFS:    lres_nxt = pwdata;
        ENC_CNT_OFS: enc_nxt  = pwdata;
        RSPD_OFS:    rspd_nxt = pwdata[15:0];
        LSPD_OFS:    lspd_nxt = pwdata[6:0];
        default:     ctrl_nxt = ctrl_r;
      endcase
    end

    // Restart copies every pending setting into use at once
    ctrl_act_nxt = restart_r ? ctrl_r : ctrl_act_r;
    ppr_act_nxt  = restart_r ? ppr_r  : ppr_act_r;
    lres_act_nxt = restart_r ? lres_r : lres_act_r;
    enc_act_nxt  = restart_r ? enc_r  : enc_act_r;
    rspd_act_nxt = restart_r ? rspd_r : rspd_act_r;
    lspd_act_nxt = restart_r ? lspd_r : lspd_act_r;

    // Slower linear travel leaves room for more output edges
    lin_rate   = {33'h0_0000_0000, lspd_act_r} * {8'h00, lres_act_r};
    cfg_ok_nxt = ~ctrl_act_r[CTRL_LINEAR] ||
                 (lin_rate <= LIN_RATE_LIMIT);
  end

  // Encoder decode and output waveform
  always_comb begin
    out_en    = ctrl_act_r[CTRL_OUT_EN] & cfg_ok_r;
    enc_idx   = {enc_b_s, enc_a_s ^ enc_b_s};
    enc_diff  = enc_idx - enc_idx_r;
    enc_step  = (enc_diff == 2'd1) | (enc_diff == 2'd3);
    motor_fwd = (enc_diff == 2'd1);
    z_rise    = enc_z_s & ~z_prev_r;

    enc_idx_nxt  = enc_idx;
    z_prev_nxt   = enc_z_s;
    last_fwd_nxt = enc_step ? motor_fwd : last_fwd_r;

    // Set wins over a software clear in the same cycle
    seq_err_nxt = seq_err_r;
    if (wr_commit && paddr == STATUS_OFS && pwdata[ST_SEQ_ERR])
      seq_err_nxt = 1'b0;
    if (enc_diff == 2'd2)
      seq_err_nxt = 1'b1;

    q_nxt   = q_r;
    pos_nxt = pos_r;
    if (div_step) begin
      q_nxt   = div_dir ? q_r + 2'd1 : q_r - 2'd1;
      pos_nxt = div_dir ? pos_r + 32'h0000_0001 : pos_r - 32'h0000_0001;
    end
    // Sequence 00,10,11,01 for A,B: B trails A by a quarter cycle
    a_nxt = q_nxt[0] ^ q_nxt[1];
    b_nxt = q_nxt[1];

    // Index is armed, then C rides the next A high phase
    c_pend_nxt = c_pend_r;
    c_nxt      = c_r;
    if (z_rise && out_en &&
        (last_fwd_r || ctrl_act_r[CTRL_C_BOTH]))
      c_pend_nxt = 1'b1;
    if (a_nxt && !quad_phase_a_out && c_pend_nxt) begin
      c_nxt      = 1'b1;
      c_pend_nxt = 1'b0;
    end else if (!a_nxt && quad_phase_a_out) begin
      c_nxt      = 1'b0;
    end
    // Reverse pass in both-direction mode starts C late: may be narrow
    if (z_rise && out_en && !last_fwd_r && ctrl_act_r[CTRL_C_BOTH] &&
        a_nxt) begin
      c_nxt      = 1'b1;
      c_pend_nxt = 1'b0;
    end
    // Above the homing speed limit an index may land between A highs
    // and be merged into the next one
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= CTRL_RST;
      ctrl_act_r <= CTRL_RST;
      ppr_r      <= PPR_RST;
      ppr_act_r  <= PPR_RST;
      lres_r     <= LRES_RST;
      lres_act_r <= LRES_RST;
      enc_r      <= ENC_CNT_RST;
      enc_act_r  <= ENC_CNT_RST;
      rspd_r     <= RSPD_RST;
      rspd_act_r <= RSPD_RST;
      lspd_r     <= LSPD_RST;
      lspd_act_r <= LSPD_RST;
      restart_r  <= 1'b0;
      cfg_ok_r   <= 1'b1;
      seq_err_r  <= 1'b0;
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      enc_idx_r  <= 2'd0;
      z_prev_r   <= 1'b0;
      last_fwd_r <= 1'b1;
      q_r        <= 2'd0;
      c_r        <= 1'b0;
      c_pend_r   <= 1'b0;
      pos_r      <= 32'h0000_0000;
      quad_phase_a_out   <= 1'b0;
      quad_phase_a_out_n <= 1'b1;
      quad_phase_b_out   <= 1'b0;
      quad_phase_b_out_n <= 1'b1;
      origin_pulse_out   <= 1'b0;
      origin_pulse_out_n <= 1'b1;
    end else begin
      ctrl_r     <= ctrl_nxt;
      ctrl_act_r <= ctrl_act_nxt;
      ppr_r      <= ppr_nxt;
      ppr_act_r  <= ppr_act_nxt;
      lres_r     <= lres_nxt;
      lres_act_r <= lres_act_nxt;
      enc_r      <= enc_nxt;
      enc_act_r  <= enc_act_nxt;
      rspd_r     <= rspd_nxt;
      rspd_act_r <= rspd_act_nxt;
      lspd_r     <= lspd_nxt;
      lspd_act_r <= lspd_act_nxt;
      restart_r  <= restart_nxt;
      cfg_ok_r   <= cfg_ok_nxt;
      seq_err_r  <= seq_err_nxt;
      prdata     <= prdata_nxt;
      pready     <= pready_nxt;
      pslverr    <= pslverr_nxt;
      enc_idx_r  <= enc_idx_nxt;
      z_prev_r   <= z_prev_nxt;
      last_fwd_r <= last_fwd_nxt;
      q_r        <= q_nxt;
      c_r        <= c_nxt;
      c_pend_r   <= c_pend_nxt;
      pos_r      <= pos_nxt;
      quad_phase_a_out   <= a_nxt;
      quad_phase_a_out_n <= ~a_nxt;
      quad_phase_b_out   <= b_nxt;
      quad_phase_b_out_n <= ~b_nxt;
      origin_pulse_out   <= c_nxt;
      origin_pulse_out_n <= ~c_nxt;
    end
  end

endmodule : edp_top

// >>> edp_pkg.sv
// Purpose: Shared constants of the encoder divided pulse output block
// Assumes: APB register map with 32-bit data and 12-bit byte addresses
// Notes:   Settings marked pending take effect only after a restart
package edp_pkg;

  localparam int          ADDR_W         = 12;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFS       = 12'h000;
  localparam logic [11:0] PPR_OFS        = 12'h004;
  localparam logic [11:0] LRES_OFS       = 12'h008;
  localparam logic [11:0] ENC_CNT_OFS    = 12'h00C;
  localparam logic [11:0] RSPD_OFS       = 12'h010;
  localparam logic [11:0] LSPD_OFS       = 12'h014;
  localparam logic [11:0] STATUS_OFS     = 12'h018;
  localparam logic [11:0] POS_OFS        = 12'h01C;

  // Control field positions
  localparam int          CTRL_LINEAR    = 0;
  localparam int          CTRL_REVERSE   = 1;
  localparam int          CTRL_C_BOTH    = 2;
  localparam int          CTRL_OUT_EN    = 3;
  localparam int          CTRL_RESTART   = 8;
  localparam int          CTRL_W         = 4;

  // Status field positions
  localparam int          ST_CFG_OK      = 0;
  localparam int          ST_SEQ_ERR     = 1;
  localparam int          ST_C_PENDING   = 2;
  localparam int          ST_C_OUT       = 3;
  localparam int          ST_PHASE_LO    = 4;

  // Reset values and ranges
  localparam logic [3:0]  CTRL_RST       = 4'h8;
  localparam logic [31:0] PPR_RST        = 32'h0000_0800;
  localparam logic [31:0] PPR_MIN        = 32'h0000_0010;
  localparam logic [31:0] PPR_MAX        = 32'h4000_0000;
  localparam logic [31:0] LRES_RST       = 32'h0000_1000;
  localparam logic [31:0] ENC_CNT_RST    = 32'h0010_0000;
  localparam logic [15:0] RSPD_RST       = 16'h2710;
  localparam logic [6:0]  LSPD_RST       = 7'h32;
  localparam logic [6:0]  LSPD_MIN       = 7'h01;
  localparam logic [6:0]  LSPD_MAX       = 7'h64;

  // Highest resolution times max linear speed that the output can follow
  localparam logic [39:0] LIN_RATE_LIMIT = 40'h00_1000_0000;

endpackage : edp_pkg

// >>> edp_sync2.sv
// Purpose: Two flip-flop synchroniser for one pin level
// Assumes: Input is asynchronous to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module edp_sync2 (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  logic meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : edp_sync2

// >>> edp_rate_div.sv
// Purpose: Fractional divider from encoder counts to output edges
// Assumes: num <= den, so at most one output edge per encoder count
// Notes:   Accumulator stays in [0, den) in both directions
`timescale 1ns/1ps
module edp_rate_div (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        step_in,
  input  wire logic        dir_in,
  input  wire logic [33:0] num,
  input  wire logic [31:0] den,
  output logic             step_out,
  output logic             dir_out
);

  logic [33:0] acc_r;
  logic [33:0] acc_nxt;
  logic        step_nxt;
  logic        dir_nxt;
  logic [33:0] sum;
  logic [33:0] den_w;

  always_comb begin
    den_w    = {2'b00, den};
    acc_nxt  = acc_r;
    step_nxt = 1'b0;
    dir_nxt  = dir_out;
    sum      = acc_r + num;
    // A smaller count per revolution after restart leaves the
    // accumulator out of range: fold it back, a step then is lost
    if (acc_r >= den_w) begin
      acc_nxt  = '0;
    end else if (step_in) begin
      dir_nxt = dir_in;
      if (dir_in) begin
        if (sum >= den_w) begin
          acc_nxt  = sum - den_w;
          step_nxt = 1'b1;
        end else begin
          acc_nxt  = sum;
        end
      end else if (acc_r >= num) begin
        acc_nxt  = acc_r - num;
      end else begin
        acc_nxt  = acc_r + den_w - num;
        step_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r    <= '0;
      step_out <= 1'b0;
      dir_out  <= 1'b1;
    end else begin
      acc_r    <= acc_nxt;
      step_out <= step_nxt;
      dir_out  <= dir_nxt;
    end
  end

endmodule : edp_rate_div

// >>> edp_top_monitor.sv
// Purpose: Concurrent checks on the ports of edp_top
// Assumes: One pclk domain, presetn asynchronous active low
// Notes:   Attached by bind below the module
`timescale 1ns/1ps
module edp_top_monitor
  import edp_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              quad_phase_a_out,
  input wire logic              quad_phase_a_out_n,
  input wire logic              quad_phase_b_out,
  input wire logic              quad_phase_b_out_n,
  input wire logic              origin_pulse_out,
  input wire logic              origin_pulse_out_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence access_s;
    psel && penable && !pready;
  endsequence
  sequence answer_s;
    psel && penable && pready;
  endsequence
  ready_wait_a: assert property (access_s |=> answer_s)
    else $error("pready late");
  ready_cause_a: assert property (pready |-> penable && $past(penable))
    else $error("pready without access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  err_valid_a: assert property (pslverr |-> pready)
    else $error("pslverr outside answer");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not idle");
  bad_addr_a: assert property (answer_s ##0 (paddr > POS_OFS) |-> pslverr)
    else $error("unmapped access accepted");
  a_inverse_a: assert property (quad_phase_a_out_n != quad_phase_a_out)
    else $error("A pair not inverse");
  b_inverse_a: assert property (quad_phase_b_out_n != quad_phase_b_out)
    else $error("B pair not inverse");
  c_inverse_a: assert property (origin_pulse_out_n != origin_pulse_out)
    else $error("C pair not inverse");
  ab_gray_a: assert property (!($changed(quad_phase_a_out) &&
    $changed(quad_phase_b_out))) else $error("A and B moved together");
  origin_width_a: assert property (origin_pulse_out |-> quad_phase_a_out)
    else $error("C high while A low");
  origin_fall_a: assert property ($fell(origin_pulse_out) |->
    $fell(quad_phase_a_out)) else $error("C fell apart from A");
endmodule : edp_top_monitor

bind edp_top edp_top_monitor edp_top_monitor_inst (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .quad_phase_a_out(quad_phase_a_out),
  .quad_phase_a_out_n(quad_phase_a_out_n),
  .quad_phase_b_out(quad_phase_b_out),
  .quad_phase_b_out_n(quad_phase_b_out_n),
  .origin_pulse_out(origin_pulse_out),
  .origin_pulse_out_n(origin_pulse_out_n));

// >>> edp_host_model.sv
// Purpose: Host side counter of the divided quadrature feedback
// Assumes: Outputs move at most one quadrature step per clock
// Notes:   A jump of two states cannot be signed, so it is a fault
`timescale 1ns/1ps
module edp_host_model (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          pa,
  input  wire logic          pa_n,
  input  wire logic          pb,
  input  wire logic          pb_n,
  input  wire logic          pc,
  input  wire logic          pc_n,
  output logic signed [31:0] edges,
  output logic        [31:0] origins,
  output logic        [31:0] faults
);
  logic [1:0] prev_r;
  logic       pc_r;
  logic [1:0] now_idx;
  logic [1:0] diff;
  // Gray order 00, 10, 11, 01 counts up
  assign now_idx = {pb, pa ^ pb};
  assign diff    = now_idx - prev_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r  <= 2'd0;
      pc_r    <= 1'b0;
      edges   <= '0;
      origins <= '0;
      faults  <= '0;
    end else begin
      prev_r <= now_idx;
      pc_r   <= pc;
      if (diff == 2'd1) edges <= edges + 1;
      else if (diff == 2'd3) edges <= edges - 1;
      else if (diff == 2'd2) faults <= faults + 1;
      if (pc && !pc_r) origins <= origins + 1;
      if (pa_n == pa || pb_n == pb || pc_n == pc) faults <= faults + 1;
    end
  end
endmodule : edp_host_model

// >>> edp_top_tb_top.sv
// Purpose: Self-checking bench for edp_top
// Assumes: 250 MHz pclk, one encoder step every four cycles
// Notes:   Edge counts come from the host model, not the design
`timescale 1ns/1ps
module edp_top_tb_top
  import edp_pkg::*;
;
  localparam logic [31:0] M = 32'hFFFF_FFFF;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              enc_a_in = 1'b0;
  logic              enc_b_in = 1'b0;
  logic              enc_z_in = 1'b0;
  logic              qa, qa_n, qb, qb_n, qc, qc_n;
  logic signed [31:0] edges, e0;
  logic [31:0]       origins, faults, c0, rd;
  logic              er;
  logic [1:0]        ph = 2'd0;
  int                seed = 32'h5440;
  int                fails = 0;
  int                num_checks = 0;
  int                ppr;
  always #2 pclk = ~pclk;
  edp_top edp_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enc_a_in(enc_a_in), .enc_b_in(enc_b_in), .enc_z_in(enc_z_in),
    .quad_phase_a_out(qa), .quad_phase_a_out_n(qa_n),
    .quad_phase_b_out(qb), .quad_phase_b_out_n(qb_n),
    .origin_pulse_out(qc), .origin_pulse_out_n(qc_n));
  edp_host_model edp_host_model_inst (.clk(pclk), .rst_n(presetn),
    .pa(qa), .pa_n(qa_n), .pb(qb), .pb_n(qb_n), .pc(qc), .pc_n(qc_n),
    .edges(edges), .origins(origins), .faults(faults));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Output edges expected from encoder counts at a given scaling
  function automatic logic [31:0] exp_edges(input int cnt, input int res,
                                            input int enc);
    longint p;
    p = longint'(cnt) * 4 * res;
    return 32'(p / enc);
  endfunction : exp_edges
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait states are the slave's: pready is sampled at rising edges
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) fails++;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic e);
    apb(1'b1, a, d);
    chk({31'h0, er}, {31'h0, e});
  endtask : wr
  task automatic rdm(input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd & m, x);
  endtask : rdm
  task automatic restart(input logic [3:0] c);
    wr(CTRL_OFS, {23'h0, 1'b1, 4'h0, c}, 1'b0);
    repeat (4) @(posedge pclk);
    e0 = edges;
    c0 = origins;
  endtask : restart
  // Four cycles a step keeps origin passes slow for the host
  task automatic steps(input int n, input logic fwd, input int zat);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      ph = fwd ? ph + 2'd1 : ph - 2'd1;
      enc_a_in <= ph[1] ^ ph[0];
      enc_b_in <= ph[1];
      enc_z_in <= (i == zat);
      repeat (3) @(posedge pclk);
    end
    repeat (10) @(posedge pclk);
  endtask : steps
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdm(CTRL_OFS, M, {28'h0, CTRL_RST});
    rdm(PPR_OFS, M, PPR_RST);
    rdm(LRES_OFS, M, LRES_RST);
    rdm(ENC_CNT_OFS, M, ENC_CNT_RST);
    rdm(RSPD_OFS, M, {16'h0, RSPD_RST});
    rdm(LSPD_OFS, M, {25'h0, LSPD_RST});
    rdm(12'h020, M, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    wr(PPR_OFS, 32'h0000_000F, 1'b1);
    wr(PPR_OFS, 32'h4000_0001, 1'b1);
    wr(PPR_OFS, PPR_MAX, 1'b0);
    wr(LSPD_OFS, 32'h0000_0065, 1'b1);
    wr(PPR_OFS, PPR_MIN, 1'b0);
    wr(ENC_CNT_OFS, 32'h0000_0040, 1'b0);
    e0 = edges;
    steps(8, 1'b1, -1);
    chk(edges - e0, 32'h0000_0000);
    $display("test registers done");
    for (int k = 0; k < 3; k++) begin
      ppr = 16 + ($random(seed) & 15);
      wr(PPR_OFS, ppr, 1'b0);
      wr(ENC_CNT_OFS, 4 * ppr, 1'b0);
      restart(4'h8);
      steps(4 * ppr, 1'b1, 2 * ppr);
      steps(4 * ppr, 1'b1, 2 * ppr);
      chk(edges - e0, exp_edges(8 * ppr, ppr, 4 * ppr));
      chk(origins - c0, 32'h0000_0002);
    end
    wr(PPR_OFS, PPR_MIN, 1'b0);
    wr(ENC_CNT_OFS, 32'h0000_0080, 1'b0);
    restart(4'h8);
    steps(64, 1'b1, -1);
    chk(edges - e0, exp_edges(64, 16, 128));
    $display("test rotary done");
    wr(ENC_CNT_OFS, 32'h0000_0040, 1'b0);
    restart(4'hA);
    steps(64, 1'b0, 32);
    chk(edges - e0, exp_edges(64, 16, 64));
    chk(origins - c0, 32'h0000_0000);
    restart(4'hE);
    steps(64, 1'b0, 32);
    chk(origins - c0, 32'h0000_0001);
    restart(4'h0);
    steps(8, 1'b1, -1);
    chk(edges - e0, 32'h0000_0000);
    $display("test direction done");
    wr(LRES_OFS, 32'h0000_0010, 1'b0);
    restart(4'h9);
    steps(20, 1'b1, -1);
    chk(edges - e0, exp_edges(20, 16, 64));
    wr(LRES_OFS, 32'h0400_0000, 1'b0);
    wr(ENC_CNT_OFS, 32'h1000_0000, 1'b0);
    restart(4'h9);
    rdm(STATUS_OFS, 32'h0000_0001, 32'h0000_0000);
    wr(LSPD_OFS, 32'h0000_0001, 1'b0);
    restart(4'h9);
    rdm(STATUS_OFS, 32'h0000_0001, 32'h0000_0001);
    // Corner: an encoder jump of two states is dropped and flagged
    @(posedge pclk);
    ph = ph + 2'd2;
    enc_a_in <= ph[1] ^ ph[0];
    enc_b_in <= ph[1];
    repeat (10) @(posedge pclk);
    rdm(STATUS_OFS, 32'h0000_0002, 32'h0000_0002);
    wr(STATUS_OFS, 32'h0000_0002, 1'b0);
    rdm(STATUS_OFS, 32'h0000_0002, 32'h0000_0000);
    rdm(POS_OFS, M, edges);
    chk(faults, 32'h0000_0000);
    $display("test linear done");
    report_and_stop();
  end
endmodule : edp_top_tb_top
